// [ddt_consts.svh]
// Constants for the termination timing controller: offsets, fields, resets and latency adders.
`ifndef DDT_CONSTS_SVH
`define DDT_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define DDT_OFS_MR1        8'h00
`define DDT_OFS_MR2        8'h04
`define DDT_OFS_MR5        8'h08
`define DDT_OFS_LAT        8'h0c
`define DDT_OFS_CTRL       8'h10
`define DDT_OFS_STAT       8'h14

// ==========================================================================
// Reset values
`define DDT_RST_MR         32'h0000_0000
`define DDT_RST_LAT        32'h0000_0009
`define DDT_RST_CTRL       32'h0000_0000

// ==========================================================================
// Mode register fields
`define DDT_NOM_HI         10
`define DDT_NOM_LO         8
`define DDT_WRT_HI         11
`define DDT_WRT_LO         9
`define DDT_DYN_A9         9
`define DDT_DYN_A10        10
`define DDT_PARK_HI        8
`define DDT_PARK_LO        6

// ==========================================================================
// Latency and control fields
`define DDT_CASLAT_HI      5
`define DDT_CASLAT_LO      0
`define DDT_ADDLAT_HI      13
`define DDT_ADDLAT_LO      8
`define DDT_PARLAT_HI      19
`define DDT_PARLAT_LO      16
`define DDT_CTRL_PRE2      0
`define DDT_CTRL_CRC       1
`define DDT_CTRL_BURST_HI  3
`define DDT_CTRL_BURST_LO  2
`define DDT_CTRL_TDIS      4

// ==========================================================================
// Latency arithmetic
`define DDT_SUB_PRE1       6'd2
`define DDT_SUB_PRE2       6'd3
`define DDT_LAT_MIN        6'd1
`define DDT_DLY_DEPTH      64
`define DDT_RD_C4_P1       4'd4
`define DDT_RD_C4_P2       4'd5
`define DDT_RD_B8_P1       4'd6
`define DDT_RD_B8_P2       4'd7
`define DDT_WR_C4_P1       4'd4
`define DDT_WR_C4_P1_CRC   4'd7
`define DDT_WR_C4_P2       4'd5
`define DDT_WR_C4_P2_CRC   4'd8
`define DDT_WR_B8_BASE     4'd6
`define DDT_WR_B8_ONE      4'd7
`define DDT_WR_B8_BOTH     4'd8

`endif

// [ddt_pkg.sv]
// Types shared by the termination timing controller.
package ddt_pkg;
    typedef enum logic [2:0] {
        DDT_TERM_HIZ,
        DDT_TERM_PARK,
        DDT_TERM_NOM,
        DDT_TERM_WR,
        DDT_TERM_DIS
    } ddt_term_t;

    typedef enum logic [1:0] {
        DDT_BL8_FIXED,
        DDT_BC4_FIXED,
        DDT_BURST_OTF
    } ddt_burst_t;
endpackage : ddt_pkg

// [ddt_delay_line.sv]
// Programmable delay line: two bits shifted per clock, tapped at a latency.
`timescale 1ns/10ps
`include "ddt_consts.svh"
module ddt_delay_line (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Data and tap select
    input  wire logic [1:0] data_i,
    input  wire logic [5:0] lat_i,
    output logic      [1:0] tap_o
);
    logic [1:0] line_reg [`DDT_DLY_DEPTH];
    wire  [5:0] tap_idx = lat_i - `DDT_LAT_MIN;

    // ======================================================================
    // Shift storage
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            for (int i = 0; i < `DDT_DLY_DEPTH; i++) begin
                line_reg[i] <= 2'h0;
            end
        end else begin
            line_reg[0] <= data_i;
            for (int i = 1; i < `DDT_DLY_DEPTH; i++) begin
                line_reg[i] <= line_reg[i-1];
            end
        end
    end

    // Latency is at least one, so the tap never underflows.
    assign tap_o = line_reg[tap_idx];
endmodule : ddt_delay_line

// [ddt_window.sv]
// Retriggerable window: active from the start cycle for len_i cycles.
`timescale 1ns/10ps
module ddt_window (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    // Control
    input  wire logic       start_i,
    input  wire logic [3:0] len_i,
    output logic            active_o
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    wire        cnt_run = (cnt_reg != 4'h0);

    // A new start restarts the window, so overlapping commands extend it.
    assign cnt_next = start_i ? (len_i - 4'h1) : (cnt_run ? (cnt_reg - 4'h1) : 4'h0);
    assign active_o = start_i | cnt_run;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : ddt_window

// [ddt_term_ctrl.sv]
// Termination timing controller: Wishbone registers, latency paths and termination select.
//
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "ddt_consts.svh"

// Summary of operation
// - Use latency-timed termination whenever the DLL is locked.
// - Nominal on/off follows the sampled pin after the direct latency.
// - Direct latency is the write latency sum minus 2, or minus 3 with long preamble.
// - After a read, termination turns off after the read turn-off latency.
// - Fixed chop-4, long preamble: park returns five cycles after turn-off.
// - Burst-8 or on-the-fly: park returns six or seven cycles after turn-off.
// - Each termination change lands within the skew window after its endpoint.
// - Never terminate while driving; enable only after the read postamble.
// - Dynamic write termination is enabled by MR2 bit 9 or bit 10.
// - Values come from MR1[10:8], MR2[11:9] and MR5[8:6].
// - Without writes, nominal follows the pin; park applies while it is low.
// - A write selects write termination after write latency minus 2 or 3.
// - Chop-4 write releases after select latency plus 4, 7, 5 or 8.
// - Burst-8 write releases after select latency plus 6, 7 or 8.
// - No dynamic write termination with the DLL off; controller gates it by lock, MR2 is left unchanged.
// - Priority is disable, then read turn-off, then write, then nominal, then park.
module ddt_term_ctrl (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Device command side
    input  wire logic              odt_i,
    input  wire logic              dll_locked_i,
    input  wire logic              wr_cmd_i,
    input  wire logic              wr_chop4_i,
    input  wire logic              rd_cmd_i,
    // Termination select
    output ddt_pkg::ddt_term_t     term_state_o,
    output logic      [2:0]        term_value_o
);
    import ddt_pkg::*;

    // ======================================================================
    // Functions
    function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : apply_sel

    function automatic logic [5:0] sub_lat(input logic [5:0] sum,
                                           input logic       pre2);
        logic [5:0] sub;
        sub = pre2 ? `DDT_SUB_PRE2 : `DDT_SUB_PRE1;
        // Saturate so a mis-programmed latency never wraps past zero.
        return (sum > sub) ? (sum - sub) : `DDT_LAT_MIN;
    endfunction : sub_lat

    // ======================================================================
    // Registers
    logic [31:0] mr1_reg;
    logic [31:0] mr2_reg;
    logic [31:0] mr5_reg;
    logic [31:0] lat_reg;
    logic [31:0] ctrl_reg;
    logic [31:0] dat_next;
    ddt_term_t   term_state_reg;
    ddt_term_t   term_state_next;
    logic [2:0]  term_value_reg;
    logic [2:0]  term_value_next;
    logic        ack_reg;
    logic [31:0] dat_reg;

    // ======================================================================
    // Wishbone decode
    wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg; // Lands on the edge where the master sees ack.
    wire sel_mr1  = (wb_adr_i == `DDT_OFS_MR1);
    wire sel_mr2  = (wb_adr_i == `DDT_OFS_MR2);
    wire sel_mr5  = (wb_adr_i == `DDT_OFS_MR5);
    wire sel_lat  = (wb_adr_i == `DDT_OFS_LAT);
    wire sel_ctrl = (wb_adr_i == `DDT_OFS_CTRL);
    wire sel_stat = (wb_adr_i == `DDT_OFS_STAT);
    wire [31:0] stat_word = {28'h0, dll_locked_i, term_state_reg};

    assign dat_next = sel_mr1  ? mr1_reg  :
                      sel_mr2  ? mr2_reg  :
                      sel_mr5  ? mr5_reg  :
                      sel_lat  ? lat_reg  :
                      sel_ctrl ? ctrl_reg :
                      sel_stat ? stat_word : 32'h0;

    // Every access is acknowledged one cycle later; unmapped reads return zero.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= bus_req ? dat_next : dat_reg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mr1_reg  <= `DDT_RST_MR;
            mr2_reg  <= `DDT_RST_MR;
            mr5_reg  <= `DDT_RST_MR;
            lat_reg  <= `DDT_RST_LAT;
            ctrl_reg <= `DDT_RST_CTRL;
        end else if (bus_wr) begin
            mr1_reg  <= sel_mr1  ? apply_sel(mr1_reg,  wb_dat_i, wb_sel_i) : mr1_reg;
            mr2_reg  <= sel_mr2  ? apply_sel(mr2_reg,  wb_dat_i, wb_sel_i) : mr2_reg;
            mr5_reg  <= sel_mr5  ? apply_sel(mr5_reg,  wb_dat_i, wb_sel_i) : mr5_reg;
            lat_reg  <= sel_lat  ? apply_sel(lat_reg,  wb_dat_i, wb_sel_i) : lat_reg;
            ctrl_reg <= sel_ctrl ? apply_sel(ctrl_reg, wb_dat_i, wb_sel_i) : ctrl_reg;
        end
    end

    // ======================================================================
    // Configuration decode
    wire [2:0] nominal_value = mr1_reg[`DDT_NOM_HI:`DDT_NOM_LO];
    wire [2:0] write_value   = mr2_reg[`DDT_WRT_HI:`DDT_WRT_LO];
    wire [2:0] park_value    = mr5_reg[`DDT_PARK_HI:`DDT_PARK_LO];
    wire dyn_enable  = mr2_reg[`DDT_DYN_A9] | mr2_reg[`DDT_DYN_A10];
    wire pre2        = ctrl_reg[`DDT_CTRL_PRE2];
    wire crc_on      = ctrl_reg[`DDT_CTRL_CRC];
    wire term_dis    = ctrl_reg[`DDT_CTRL_TDIS];
    wire [1:0] burst = ctrl_reg[`DDT_CTRL_BURST_HI:`DDT_CTRL_BURST_LO];
    wire bc4_fixed   = (burst == DDT_BC4_FIXED);
    wire sync_mode   = dll_locked_i;

    // The sum wraps above 63 cycles; legal settings stay far below that.
    wire [5:0] cas_write_latency = lat_reg[`DDT_CASLAT_HI:`DDT_CASLAT_LO];
    wire [5:0] additive_latency  = lat_reg[`DDT_ADDLAT_HI:`DDT_ADDLAT_LO];
    wire [5:0] parity_latency    = {2'h0, lat_reg[`DDT_PARLAT_HI:`DDT_PARLAT_LO]};
    wire [5:0] write_latency     = cas_write_latency + additive_latency + parity_latency;
    wire [5:0] direct_term_on_latency    = sub_lat(write_latency, pre2);
    wire [5:0] read_term_off_latency     = sub_lat(write_latency, pre2);
    wire [5:0] write_term_select_latency = sub_lat(write_latency, pre2);

    // Park return after a read, counted from the read turn-off endpoint.
    wire [3:0] rd_park_add = bc4_fixed ? (pre2 ? `DDT_RD_C4_P2 : `DDT_RD_C4_P1)
                                       : (pre2 ? `DDT_RD_B8_P2 : `DDT_RD_B8_P1);

    // ======================================================================
    // Latency paths
    logic [1:0] odt_tap;
    logic [1:0] wr_tap;
    logic [1:0] rd_tap;
    logic       wr_win;
    logic       rd_win;
    wire        wr_chop = bc4_fixed | ((burst == DDT_BURST_OTF) & wr_chop4_i);

    // On and off latencies are equal, so delaying the pin level covers both.
    ddt_delay_line u_odt_dly (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .data_i    ({1'b0, odt_i}),
        .lat_i     (direct_term_on_latency),
        .tap_o     (odt_tap)
    );

    ddt_delay_line u_wr_dly (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .data_i    ({wr_chop, wr_cmd_i}),
        .lat_i     (write_term_select_latency),
        .tap_o     (wr_tap)
    );

    ddt_delay_line u_rd_dly (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .data_i    ({1'b0, rd_cmd_i}),
        .lat_i     (read_term_off_latency),
        .tap_o     (rd_tap)
    );

    // The burst kind travels with the write, so a later mode change does not
    // alter a window already in flight.
    wire [3:0] wr_rel_add = wr_tap[1] ?
        (pre2 ? (crc_on ? `DDT_WR_C4_P2_CRC : `DDT_WR_C4_P2)
              : (crc_on ? `DDT_WR_C4_P1_CRC : `DDT_WR_C4_P1)) :
        ((crc_on & pre2) ? `DDT_WR_B8_BOTH :
         ((crc_on | pre2) ? `DDT_WR_B8_ONE : `DDT_WR_B8_BASE));

    ddt_window u_wr_win (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .start_i   (wr_tap[0]),
        .len_i     (wr_rel_add),
        .active_o  (wr_win)
    );

    ddt_window u_rd_win (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .start_i   (rd_tap[0]),
        .len_i     (rd_park_add),
        .active_o  (rd_win)
    );

    // ======================================================================
    // Termination select
    // Outside lock the pin is used undelayed and write termination is barred.
    wire odt_eff   = sync_mode ? odt_tap[0] : odt_i;
    wire wr_active = wr_win & dyn_enable & sync_mode;
    wire nom_on    = odt_eff & (nominal_value != 3'h0);
    wire park_on   = (park_value != 3'h0);

    // Read turn-off outranks write select: the device drives the lines then.
    assign term_state_next = term_dis  ? DDT_TERM_DIS  :
                             rd_win    ? DDT_TERM_HIZ  :
                             wr_active ? DDT_TERM_WR   :
                             nom_on    ? DDT_TERM_NOM  :
                             park_on   ? DDT_TERM_PARK : DDT_TERM_HIZ;

    assign term_value_next = (term_state_next == DDT_TERM_WR)   ? write_value   :
                             (term_state_next == DDT_TERM_NOM)  ? nominal_value :
                             (term_state_next == DDT_TERM_PARK) ? park_value    : 3'h0;

    // Registered at the endpoint edge, well inside the allowed change skew.
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            term_state_reg <= DDT_TERM_HIZ;
            term_value_reg <= 3'h0;
        end else begin
            term_state_reg <= term_state_next;
            term_value_reg <= term_value_next;
        end
    end

    assign term_state_o = term_state_reg;
    assign term_value_o = term_value_reg;
    assign wb_ack_o     = ack_reg;
    assign wb_dat_o     = dat_reg;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_dis_first;
        term_dis |=> term_state_o == DDT_TERM_DIS;
    endproperty
    a_dis_first: assert property (p_dis_first) else $error("disable did not win");

    property p_read_hiz;
        rd_tap[0] && !term_dis |=> (term_state_o == DDT_TERM_HIZ) [*1];
    endproperty
    a_read_hiz: assert property (p_read_hiz) else $error("read turn-off missed");

    property p_no_term_in_read;
        rd_win && !term_dis |=> term_value_o == 3'h0;
    endproperty
    a_no_term_in_read: assert property (p_no_term_in_read) else $error("terminated while driving");

    property p_wr_select;
        wr_tap[0] && dyn_enable && sync_mode && !term_dis && !rd_win |=> term_state_o == DDT_TERM_WR;
    endproperty
    a_wr_select: assert property (p_wr_select) else $error("write term not selected");

    property p_no_dyn;
        !dyn_enable |=> term_state_o != DDT_TERM_WR;
    endproperty
    a_no_dyn: assert property (p_no_dyn) else $error("write term while dynamic off");

    property p_dll_off;
        !dll_locked_i |=> term_state_o != DDT_TERM_WR;
    endproperty
    a_dll_off: assert property (p_dll_off) else $error("write term with DLL off");

    property p_nom_value;
        term_state_o == DDT_TERM_NOM |-> term_value_o == $past(nominal_value);
    endproperty
    a_nom_value: assert property (p_nom_value) else $error("wrong nominal value");

    property p_park_low;
        !odt_eff && !wr_win && !rd_win && !term_dis && park_on |=> term_state_o == DDT_TERM_PARK;
    endproperty
    a_park_low: assert property (p_park_low) else $error("park not applied");

    property p_direct_lat;
        sync_mode && odt_tap[0] && !$past(odt_tap[0]) && nominal_value != 3'h0
            && !term_dis && !wr_win && !rd_win |=> term_state_o == DDT_TERM_NOM;
    endproperty
    a_direct_lat: assert property (p_direct_lat) else $error("nominal not on at latency");

    property p_lat_calc;
        write_latency > 6'd3 |-> direct_term_on_latency == write_latency - (pre2 ? 6'd3 : 6'd2);
    endproperty
    a_lat_calc: assert property (p_lat_calc) else $error("direct latency wrong");

    property p_b8_len;
        wr_tap[0] && !wr_tap[1] && !crc_on && !pre2 |-> wr_rel_add == 4'd6;
    endproperty
    a_b8_len: assert property (p_b8_len) else $error("burst-8 release wrong");

    property p_c4_len;
        wr_tap[0] && wr_tap[1] && crc_on && pre2 |-> wr_rel_add == 4'd8;
    endproperty
    a_c4_len: assert property (p_c4_len) else $error("chop-4 release wrong");

    property p_rd_c4;
        bc4_fixed && pre2 |-> rd_park_add == 4'd5;
    endproperty
    a_rd_c4: assert property (p_rd_c4) else $error("chop-4 park return wrong");

    property p_rd_b8;
        !bc4_fixed |-> rd_park_add == (pre2 ? 4'd7 : 4'd6);
    endproperty
    a_rd_b8: assert property (p_rd_b8) else $error("burst-8 park return wrong");

    c_wr_term: cover property (term_state_o == DDT_TERM_WR ##1 term_state_o == DDT_TERM_NOM);
    c_read:    cover property (term_state_o == DDT_TERM_HIZ ##1 term_state_o == DDT_TERM_PARK);
    c_nom:     cover property (term_state_o == DDT_TERM_PARK ##1 term_state_o == DDT_TERM_NOM);
endmodule : ddt_term_ctrl

// [ddt_ctl_model.sv]
// Behavioural memory controller that drives the termination pin and command pulses.
`timescale 1ns/10ps
module ddt_ctl_model #(
    parameter int HOLD_MIN = 8
) (
    // Clock
    input  wire logic clk_sys_i,
    // Pin and commands
    output logic      odt_o,
    output logic      wr_cmd_o,
    output logic      wr_chop4_o,
    output logic      rd_cmd_o
);
    int hi_cnt;

    initial begin
        odt_o = 1'b0;
        wr_cmd_o = 1'b0;
        wr_chop4_o = 1'b0;
        rd_cmd_o = 1'b0;
        hi_cnt = 0;
    end

    // Commands are single-cycle pulses; the chop select flips once the command is gone.
    always @(posedge clk_sys_i) begin
        hi_cnt <= odt_o ? hi_cnt + 1 : 0;
        if (wr_cmd_o || rd_cmd_o) begin
            wr_cmd_o <= 1'b0;
            rd_cmd_o <= 1'b0;
            wr_chop4_o <= ~wr_chop4_o;
        end
    end

    task cmd(input bit w, input bit ch);
        if (w) begin
            wr_cmd_o <= 1'b1;
            wr_chop4_o <= ch;
        end else begin
            rd_cmd_o <= 1'b1;
        end
    endtask : cmd

    // HOLD_MIN must be raised by the user when CRC or the long preamble is on.
    task set_odt(input bit v);
        while (!v && hi_cnt < HOLD_MIN) @(posedge clk_sys_i);
        odt_o <= v;
    endtask : set_odt
endmodule : ddt_ctl_model

// [tb.sv]
// Self-checking bench for the termination timing controller.
`timescale 1ns/10ps
`include "ddt_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb;
    import ddt_pkg::*;
    typedef struct { int at; ddt_term_t st; logic [2:0] v; } ddt_exp_t;
    logic        clk_sys_i = 1'b0, reset_i = 1'b1, dll_locked_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rv;
    logic        wb_ack_o, odt_i, wr_cmd_i, wr_chop4_i, rd_cmd_i;
    ddt_term_t   term_state_o;
    logic [2:0]  term_value_o, park;
    int          cyc = 0, err_count = 0, check_count = 0, t;
    ddt_exp_t    exp_q[$], e;
    logic [31:0] rd_q[$];

    always #2.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;

    ddt_term_ctrl DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .odt_i(odt_i), .dll_locked_i(dll_locked_i), .wr_cmd_i(wr_cmd_i),
        .wr_chop4_i(wr_chop4_i), .rd_cmd_i(rd_cmd_i), .term_state_o(term_state_o), .term_value_o(term_value_o));
    ddt_ctl_model ctl (.clk_sys_i(clk_sys_i), .odt_o(odt_i), .wr_cmd_o(wr_cmd_i), .wr_chop4_o(wr_chop4_i),
        .rd_cmd_o(rd_cmd_i));

    // ======================================================================
    // Result watcher: outputs are looked at mid-cycle, where they are settled.
    always @(negedge clk_sys_i) begin
        while (exp_q.size() > 0 && exp_q[0].at <= cyc) begin
            e = exp_q.pop_front();
            `CHK(term_state_o, e.st)
            `CHK(term_value_o, e.v)
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
            rv = rd_q.pop_front();
            `CHK(wb_dat_o, rv)
        end
    end

    // ======================================================================
    // Bus and scenario tasks
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wb

    task rd(input logic [7:0] a, input logic [31:0] x);
        rd_q.push_back(x);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    task push(input int at, input ddt_term_t st, input logic [2:0] v);
        exp_q.push_back('{at, st, v});
    endtask : push

    task burst(input logic [4:0] c, input logic [19:0] l, input logic [11:0] m2, input bit w, input bit ch,
               input int n);
        int        lat;
        ddt_term_t s;
        logic [2:0] v;
        wb(1'b1, `DDT_OFS_CTRL, {27'h0, c}, 4'hf);
        wb(1'b1, `DDT_OFS_LAT, {12'h0, l}, 4'hf);
        wb(1'b1, `DDT_OFS_MR2, {20'h0, m2}, 4'hf);
        lat = l[5:0] + l[13:8] + l[19:16] - 2 - c[0];
        s = !w ? DDT_TERM_HIZ : (m2[10:9] != 2'h0 ? DDT_TERM_WR : DDT_TERM_PARK);
        v = (s == DDT_TERM_WR) ? m2[11:9] : (s == DDT_TERM_PARK) ? park : 3'h0;
        repeat (2) @(posedge clk_sys_i);
        ctl.cmd(w, ch);
        t = cyc + 2 + lat;
        push(t - 1, DDT_TERM_PARK, park);
        push(t, s, v);
        push(t + n - 1, s, v);
        push(t + n, DDT_TERM_PARK, park);
        repeat (lat + n + 3) @(posedge clk_sys_i);
        $display("Test done: burst ctrl %h kind %0d", c, w);
    endtask : burst

    task finish_test();
        $display("Counts: %0d checks, %0d mismatches", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        err_count++;
        finish_test();
    end

    // ======================================================================
    // Main sequence
    initial begin
        void'($urandom(32'hb534));
        park = 3'($urandom_range(7, 1));
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(`DDT_OFS_LAT, `DDT_RST_LAT);
        rd(`DDT_OFS_CTRL, `DDT_RST_CTRL);
        rd(`DDT_OFS_STAT, 32'h0000_0008);
        wb(1'b1, 8'h20, $urandom, 4'hf);
        rd(8'h20, 32'h0);
        wb(1'b1, `DDT_OFS_STAT, 32'hffff_ffff, 4'hf);
        rd(`DDT_OFS_STAT, 32'h0000_0008);
        wb(1'b1, `DDT_OFS_MR1, 32'hffff_ffff, 4'h2);
        rd(`DDT_OFS_MR1, 32'h0000_ff00);
        $display("Test done: registers");
        wb(1'b1, `DDT_OFS_MR1, 32'h0000_0300, 4'hf);
        wb(1'b1, `DDT_OFS_MR5, {23'h0, park, 6'h0}, 4'hf);
        burst(5'h05, 20'h00009, 12'h200, 1'b0, 1'b0, 5);
        burst(5'h00, 20'h1020a, 12'h200, 1'b0, 1'b0, 6);
        burst(5'h09, 20'h00009, 12'h200, 1'b0, 1'b0, 7);
        burst(5'h00, 20'h00009, 12'h000, 1'b1, 1'b0, 6);
        burst(5'h02, 20'h00009, 12'h400, 1'b1, 1'b0, 7);
        burst(5'h01, 20'h00009, 12'h600, 1'b1, 1'b0, 7);
        burst(5'h03, 20'h00009, 12'h200, 1'b1, 1'b0, 8);
        burst(5'h04, 20'h00009, 12'h200, 1'b1, 1'b1, 4);
        burst(5'h06, 20'h00009, 12'h200, 1'b1, 1'b1, 7);
        burst(5'h05, 20'h00009, 12'h200, 1'b1, 1'b1, 5);
        burst(5'h07, 20'h00009, 12'h200, 1'b1, 1'b1, 8);
        burst(5'h08, 20'h0020a, 12'h200, 1'b1, 1'b1, 4);
        burst(5'h00, 20'h00009, 12'h200, 1'b1, 1'b0, 6);
        ctl.set_odt(1'b1);
        t = cyc + 9;
        push(t - 1, DDT_TERM_PARK, park);
        push(t, DDT_TERM_NOM, 3'h3);
        repeat (10) @(posedge clk_sys_i);
        ctl.cmd(1'b1, 1'b0);
        t = cyc + 9;
        push(t, DDT_TERM_WR, 3'h1);
        push(t + 5, DDT_TERM_WR, 3'h1);
        push(t + 6, DDT_TERM_NOM, 3'h3);
        repeat (16) @(posedge clk_sys_i);
        ctl.set_odt(1'b0);
        t = cyc + 9;
        push(t - 1, DDT_TERM_NOM, 3'h3);
        push(t, DDT_TERM_PARK, park);
        repeat (12) @(posedge clk_sys_i);
        $display("Test done: pin control");
        dll_locked_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        ctl.cmd(1'b1, 1'b0);
        t = cyc + 9;
        push(t, DDT_TERM_PARK, park);
        push(t + 3, DDT_TERM_PARK, park);
        repeat (14) @(posedge clk_sys_i);
        dll_locked_i <= 1'b1;
        $display("Test done: locked off");
        wb(1'b1, `DDT_OFS_CTRL, 32'h0000_0010, 4'hf);
        repeat (3) @(posedge clk_sys_i);
        push(cyc + 2, DDT_TERM_DIS, 3'h0);
        ctl.cmd(1'b1, 1'b0);
        t = cyc + 9;
        push(t, DDT_TERM_DIS, 3'h0);
        repeat (12) @(posedge clk_sys_i);
        $display("Test done: disable");
        finish_test();
    end
endmodule : tb
